// file: src/ssll_device.sv
// Function
// R1 - Three host inputs, write only, no readback
// R2 - Sample data on each serial clock rise; device ignores rises while strobe is high
// R3 - Strobe rise copies word to selected latch
// R4 - Only complete 24-bit words update latches
// R5 - Host serial clock at most 20 MHz
// R6 - Host holds strobe low across word
// R7 - Host may send three gapless bytes
// R8 - Host raises strobe after third byte
// R9 - Host samples stable data, phase zero
// R10 - Power-down driven on separate line
// R11 - Host polls lock on status output
// R12 - Word shifted most significant bit first
// R13 - Low bits select reference, AB, function latch
// R14 - Loading continues while powered down
// R15 - Control code 11 updates no latch
//
// Device end: samples the link pins on clk and fills three latches.
// Assumes link pins are asynchronous to clk and below a quarter of its rate.
`timescale 1ns/1ps
module ssll_device
   import ssll_pkg::*;
(
   // System
   input  wire logic        clk,
   input  wire logic        rst,
   // Link
   ssll_if.device           link,
   // Latch contents and status flags
   output logic [23:0]      refLatch,
   output logic [23:0]      abLatch,
   output logic [23:0]      funcLatch,
   output logic             poweredDown,
   output logic             wordError,
   // Lock indication from the synthesizer core
   input  wire logic        lockDetect
);
   // Positions of the link pins in the synchroniser bank
   localparam int PIN_CLK   = 0;
   localparam int PIN_DATA  = 1;
   localparam int PIN_STB   = 2;
   localparam int PIN_CE    = 3;
   localparam int NUM_PINS  = 4;
   localparam int NUM_LATCH = 3;
   // Idle levels: clock low, data low, strobe high, enable high
   localparam logic [NUM_PINS-1:0] PIN_IDLE   = 4'hC;
   localparam logic [4:0]          COUNT_LAST = 5'(WORD_BITS - 1);
   localparam logic [2:0]          MUX_LOCK   = 3'h1;

   // Ports, counter and decode are sized for this word layout only
   if (WORD_BITS != 24 || CTRL_BITS != 2) begin : g_bad_layout
      $error("word layout does not fit the latch ports");
   end

   // Frame progress; Gray steps along idle, shift, full, over
   typedef enum logic [1:0] {
      FRAME_IDLE  = 2'b00,
      FRAME_SHIFT = 2'b01,
      FRAME_FULL  = 2'b11,
      FRAME_OVER  = 2'b10
   } ssll_frame_e;

   // One-hot latch select; code 11 selects nothing
   function automatic logic [NUM_LATCH-1:0] dest_select(input logic [1:0] code);
      logic [NUM_LATCH-1:0] hit;
      hit = 3'h0;
      case (code)
         DEST_REF:  hit = 3'h1; // R13
         DEST_AB:   hit = 3'h2; // R13
         DEST_FUNC: hit = 3'h4; // R13
         default:   hit = 3'h0; // R15
      endcase
      return hit;
   endfunction : dest_select

   // Edge seen between the settled level and its previous sample
   function automatic logic rise_of(input logic level, input logic prior);
      return level & ~prior;
   endfunction : rise_of

   logic [NUM_PINS-1:0] pinRaw, pinSafe;

   // Bit order follows the pin positions above
   assign pinRaw = {link.chipEnable, link.latchStrobe, link.serialData, link.serialClk};

   // Two stages per pin; logic reads only the second
   for (genvar p = 0; p < NUM_PINS; p++) begin : g_sync
      logic [1:0] stage, next_stage;
      always_comb begin
         next_stage = {stage[0], pinRaw[p]};
      end
      always_ff @(posedge clk) begin
         if (rst) begin
            stage <= {2{PIN_IDLE[p]}};
         end else begin
            stage <= next_stage;
         end
      end
      assign pinSafe[p] = stage[1];
   end

   ssll_frame_e          frame, next_frame;
   logic [23:0]          shiftReg, next_shiftReg;
   logic [4:0]           bitCount, next_bitCount;
   logic                 clkLast, next_clkLast, stbLast, next_stbLast;
   logic                 clkRise, stbRise, shiftNow, wordFull;
   logic [NUM_LATCH-1:0] loadEn;

   assign clkRise  = rise_of(pinSafe[PIN_CLK], clkLast);
   assign stbRise  = rise_of(pinSafe[PIN_STB], stbLast);
   // Edges outside a frame are ignored
   assign shiftNow = clkRise & ~pinSafe[PIN_STB];
   assign wordFull = (frame == FRAME_FULL);
   assign loadEn   = dest_select(shiftReg[CTRL_BITS-1:0]);

   always_comb begin
      next_clkLast  = pinSafe[PIN_CLK];
      next_stbLast  = pinSafe[PIN_STB];
      next_shiftReg = shiftReg;
      next_bitCount = bitCount;
      next_frame    = frame;
      if (shiftNow) begin
         next_shiftReg = {shiftReg[22:0], pinSafe[PIN_DATA]}; // R2 R12
         next_bitCount = bitCount + 5'h01;
      end
      // Only a frame ending exactly on the last bit may commit
      case (frame)
         FRAME_IDLE: begin
            if (!pinSafe[PIN_STB]) begin
               next_frame = FRAME_SHIFT;
            end
         end
         FRAME_SHIFT: begin
            if (shiftNow && bitCount == COUNT_LAST) begin
               next_frame = FRAME_FULL;
            end
         end
         FRAME_FULL: begin
            if (shiftNow) begin
               next_frame = FRAME_OVER;
            end
         end
         // Counter may wrap here; the state keeps the frame refused
         FRAME_OVER: next_frame = FRAME_OVER;
         default:    next_frame = FRAME_IDLE;
      endcase
      if (stbRise) begin
         next_bitCount = 5'h00;
         next_frame    = FRAME_IDLE;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         frame    <= FRAME_IDLE;
         clkLast  <= PIN_IDLE[PIN_CLK];
         stbLast  <= PIN_IDLE[PIN_STB];
         shiftReg <= 24'h000000;
         bitCount <= 5'h00;
      end else begin
         frame    <= next_frame;
         clkLast  <= next_clkLast;
         stbLast  <= next_stbLast;
         shiftReg <= next_shiftReg;
         bitCount <= next_bitCount;
      end
   end

   // One register per destination; a commit loads only the selected one
   for (genvar n = 0; n < NUM_LATCH; n++) begin : g_latch
      logic [23:0] q, next_q;
      always_comb begin
         next_q = q;
         // Power-down does not gate the commit
         if (stbRise && wordFull && loadEn[n]) begin // R3 R4 R14
            next_q = shiftReg;
         end
      end
      always_ff @(posedge clk) begin
         if (rst) begin
            q <= LATCH_RST;
         end else begin
            q <= next_q;
         end
      end
   end

   assign refLatch  = g_latch[0].q;
   assign abLatch   = g_latch[1].q;
   assign funcLatch = g_latch[2].q;

   logic next_wordError, next_poweredDown, next_status_mux_output;

   always_comb begin
      next_wordError = wordError;
      // A short or overlong frame is flagged and loads nothing
      if (stbRise) begin
         next_wordError = !wordFull; // R4
      end
      // Pin and software power-down both count
      next_poweredDown = ~pinSafe[PIN_CE] | funcLatch[POWER_DOWN_BIT]; // R10
      next_status_mux_output      = 1'b0;
      if (funcLatch[MUX_CTRL_LSB +: MUX_CTRL_BITS] == MUX_LOCK) begin
         next_status_mux_output = lockDetect & ~next_poweredDown; // R11
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         wordError            <= 1'b0;
         poweredDown          <= 1'b1;
         link.statusMuxOutput <= 1'b0;
      end else begin
         wordError            <= next_wordError;
         poweredDown          <= next_poweredDown;
         link.statusMuxOutput <= next_status_mux_output;
      end
   end
endmodule : ssll_device

// file: pkg/ssll_pkg.sv
// Shared constants for the three-wire synthesizer load port.
// Assumes both ends run on one 50 MHz system clock.
package ssll_pkg;
   localparam int WORD_BITS      = 24;
   localparam int CTRL_BITS      = 2;
   localparam int CLK_HZ         = 50000000;
   localparam int SCLK_MAX_HZ    = 20000000;
   // Least half-period of the serial clock, rounded up to whole cycles
   localparam int SCLK_HALF_MIN  = (CLK_HZ + 2 * SCLK_MAX_HZ - 1) / (2 * SCLK_MAX_HZ);
   localparam int SCLK_HALF_DFLT = 4;
   localparam logic [1:0] DEST_REF  = 2'h0;
   localparam logic [1:0] DEST_AB   = 2'h1;
   localparam logic [1:0] DEST_FUNC = 2'h2;
   localparam logic [1:0] DEST_NONE = 2'h3;
   localparam logic [23:0] LATCH_RST = 24'h000000;
   localparam int POWER_DOWN_BIT = 3;
   localparam int COUNTER_RST_BIT = 2;
   localparam int MUX_CTRL_LSB   = 4;
   localparam int MUX_CTRL_BITS  = 3;
   typedef enum logic [1:0] {
      SSLL_IDLE  = 2'b00,
      SSLL_LOW   = 2'b01,
      SSLL_HIGH  = 2'b11,
      SSLL_COMMIT = 2'b10
   } ssll_host_e;
endpackage : ssll_pkg

// file: pkg/ssll_if.sv
// Three write-only serial wires plus the power-down and status side lines.
// Both ends attach through their modports; the bench owns the clock.
`timescale 1ns/1ps
interface ssll_if;
   logic serialClk;
   logic serialData;
   logic latchStrobe;
   logic chipEnable;
   logic statusMuxOutput;
   modport device (input serialClk, input serialData, input latchStrobe,
                    input chipEnable, output statusMuxOutput);
   modport host   (output serialClk, output serialData, output latchStrobe,
                    output chipEnable, input statusMuxOutput);
endinterface : ssll_if

// file: src/ssll_host.sv
// Host end: serialises one 24-bit word per request on a divided clock.
// Assumes a single requester on clk; status line is asynchronous.
`timescale 1ns/1ps
module ssll_host
   import ssll_pkg::*;
#(
   parameter int HALF_PERIOD = SCLK_HALF_DFLT
)(
   // System
   input  wire logic        clk,
   input  wire logic        rst,
   // Link
   ssll_if.host             link,
   // User request
   input  wire logic        writeValid,
   input  wire logic [23:0] writeWord,
   output logic             writeReady,
   // Side lines
   input  wire logic        powerDownReq,
   output logic             lockStatus
);
   // Divider is eight bits; faster settings would break the link rate limit
   if (HALF_PERIOD < SCLK_HALF_MIN || HALF_PERIOD > 255) begin : g_bad_half
      $error("HALF_PERIOD out of range");
   end

   ssll_host_e  state, next_state;
   logic [7:0]  divCount, next_divCount;
   logic [4:0]  bitCount, next_bitCount;
   logic [23:0] word, next_word;
   logic        sclk, next_sclk, le, next_le, sdat, next_sdat, next_ready;
   logic [1:0]  lockSync;
   logic        tick;

   assign tick = (divCount == 8'(HALF_PERIOD - 1));

   always_comb begin
      next_state    = state;
      next_divCount = tick ? 8'h00 : divCount + 8'h01;
      next_bitCount = bitCount;
      next_word     = word;
      next_sclk     = sclk;
      next_le       = le;
      next_sdat     = sdat;
      next_ready    = 1'b0;
      case (state)
         SSLL_IDLE: begin
            next_ready = 1'b1;
            if (writeValid && writeReady) begin
               next_word     = writeWord;
               next_le       = 1'b0; // R6
               next_sdat     = writeWord[WORD_BITS-1]; // R12
               next_bitCount = 5'h00;
               next_divCount = 8'h00;
               next_ready    = 1'b0;
               next_state    = SSLL_LOW;
            end
         end
         SSLL_LOW: if (tick) begin
            next_sclk  = 1'b1; // R9 R5
            next_state = SSLL_HIGH;
         end
         SSLL_HIGH: if (tick) begin
            next_sclk = 1'b0;
            next_word = {word[22:0], 1'b0};
            next_sdat = word[22];
            if (bitCount == 5'(WORD_BITS - 1)) begin
               next_state = SSLL_COMMIT; // R7
            end else begin
               next_bitCount = bitCount + 5'h01;
               next_state    = SSLL_LOW;
            end
         end
         SSLL_COMMIT: if (tick) begin
            next_le    = 1'b1; // R8 R4
            next_state = SSLL_IDLE;
         end
         default: next_state = SSLL_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state      <= SSLL_IDLE;
         divCount   <= 8'h00;
         bitCount   <= 5'h00;
         word       <= 24'h000000;
         sclk       <= 1'b0;
         le         <= 1'b1;
         sdat       <= 1'b0;
         writeReady <= 1'b0;
         lockSync   <= 2'h0;
         lockStatus <= 1'b0;
         link.chipEnable <= 1'b0;
      end else begin
         state      <= next_state;
         divCount   <= next_divCount;
         bitCount   <= next_bitCount;
         word       <= next_word;
         sclk       <= next_sclk;
         le         <= next_le;
         sdat       <= next_sdat;
         writeReady <= next_ready;
         lockSync   <= {lockSync[0], link.statusMuxOutput}; // R11
         lockStatus <= lockSync[1];
         link.chipEnable <= ~powerDownReq; // R10
      end
   end

   // The three write wires reach the device from these registers; chipEnable is registered above
   assign link.serialClk   = sclk; // R1
   assign link.serialData  = sdat;
   assign link.latchStrobe = le;
endmodule : ssll_host

// file: sim/ssll_props.sv
// Timing and framing assertions for the serial load link.
// Assumes the host end drives the link and both ends share clk.
`timescale 1ns/1ps
module ssll_props
   import ssll_pkg::*;
#(
   parameter int HALF_PERIOD = SCLK_HALF_DFLT
)(
   // System
   input wire logic clk,
   input wire logic rst,
   // Link
   input wire logic serialClk,
   input wire logic serialData,
   input wire logic latchStrobe,
   input wire logic chipEnable,
   input wire logic statusMuxOutput
);
   logic       prevClk, prevStb, next_prevClk, next_prevStb;
   logic [7:0] lvlCnt, bitCnt, next_lvlCnt, next_bitCnt;
   // Level age restarts on any clock or strobe change
   always_comb begin
      next_prevClk = serialClk;
      next_prevStb = latchStrobe;
      next_lvlCnt  = (serialClk != prevClk || latchStrobe != prevStb) ? 8'h01 : lvlCnt + 8'h01;
      next_bitCnt  = latchStrobe ? 8'h00 : bitCnt + {7'h00, serialClk & ~prevClk};
      if (rst) begin
         next_lvlCnt = 8'h00;
         next_bitCnt = 8'h00;
      end
   end
   always_ff @(posedge clk) begin
      prevClk <= next_prevClk;
      prevStb <= next_prevStb;
      lvlCnt  <= next_lvlCnt;
      bitCnt  <= next_bitCnt;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   a_level_width: assert property (serialClk != prevClk |-> lvlCnt == HALF_PERIOD)
      else $error("serial clock level width wrong");
   a_commit_time: assert property ($rose(latchStrobe) |-> lvlCnt == HALF_PERIOD && !serialClk)
      else $error("strobe rise badly placed");
   a_word_bits: assert property ($rose(latchStrobe) |-> bitCnt == WORD_BITS)
      else $error("word bit count wrong");
   a_clock_idle: assert property (latchStrobe |-> !serialClk)
      else $error("serial clock moved outside frame");
   a_data_stable: assert property (serialClk && prevClk |-> $stable(serialData))
      else $error("data changed while clock high");
   a_data_moves: assert property (!latchStrobe && $changed(serialData)
      |-> $fell(serialClk) || $fell(latchStrobe))
      else $error("data changed off a falling clock");
   a_frame_held: assert property ($fell(latchStrobe) |-> !latchStrobe [*8])
      else $error("strobe frame too short");
   a_status_off: assert property (!chipEnable [*8] |-> !statusMuxOutput)
      else $error("status high while disabled");
   c_commit: cover property ($rose(latchStrobe));
   c_power_down: cover property ($fell(chipEnable));
   c_lock_seen: cover property (statusMuxOutput);
endmodule : ssll_props

// file: sim/synth_serial_latch_loader_test.sv
// Host end drives device end; a second device is bit-banged with bad words.
// Assumes 50 MHz clk and the default host half period.
`timescale 1ns/1ps
module synth_serial_latch_loader_test import ssll_pkg::*; ;
   logic        clk, rst, writeValid, writeReady, powerDownReq, lockStatus, lockDetect;
   logic        poweredDown, wordError, badError;
   logic [23:0] writeWord, refLatch, abLatch, funcLatch, badRef;
   int          num_errors = 0;
   int          num_checks = 0;
   ssll_if lnk();
   ssll_if badLnk();
   ssll_host #(.HALF_PERIOD(SCLK_HALF_DFLT)) ssll_host_inst (.clk(clk), .rst(rst),
      .link(lnk.host), .writeValid(writeValid), .writeWord(writeWord),
      .writeReady(writeReady), .powerDownReq(powerDownReq), .lockStatus(lockStatus));
   ssll_device ssll_device_inst (.clk(clk), .rst(rst), .link(lnk.device), .refLatch(refLatch),
      .abLatch(abLatch), .funcLatch(funcLatch), .poweredDown(poweredDown),
      .wordError(wordError), .lockDetect(lockDetect));
   ssll_device ssll_device_inst_b (.clk(clk), .rst(rst), .link(badLnk.device),
      .refLatch(badRef), .abLatch(), .funcLatch(), .poweredDown(), .wordError(badError),
      .lockDetect(1'b0));
   ssll_props #(.HALF_PERIOD(SCLK_HALF_DFLT)) ssll_props_inst (.clk(clk), .rst(rst),
      .serialClk(lnk.serialClk), .serialData(lnk.serialData), .latchStrobe(lnk.latchStrobe),
      .chipEnable(lnk.chipEnable), .statusMuxOutput(lnk.statusMuxOutput));
   initial clk = 1'b0;
   always #10 clk = ~clk;
   task automatic check(input logic [23:0] seen, input logic [23:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic complete_run();
      $display("Checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : complete_run
   task automatic wait_ready();
      repeat (400) if (writeReady !== 1'b1) @(negedge clk);
      check({23'h0, writeReady}, 24'h000001);
   endtask : wait_ready
   // Returns once the selected latch has had time to update
   task automatic send(input logic [23:0] w);
      wait_ready();
      writeWord  = w;
      writeValid = 1'b1;
      @(negedge clk);
      writeValid = 1'b0;
      @(negedge clk);
      wait_ready();
      repeat (5) @(negedge clk);
   endtask : send
   // Bench clock of 160 ns, all edges inside the frame while strobe is low
   task automatic bang(input logic [31:0] v, input int n);
      badLnk.latchStrobe = 1'b0;
      for (int i = n - 1; i >= 0; i--) begin
         badLnk.serialData = v[i];
         #80 badLnk.serialClk = 1'b1;
         #80 badLnk.serialClk = 1'b0;
      end
      #80 badLnk.latchStrobe = 1'b1;
      badLnk.serialData = ~badLnk.serialData;
      repeat (6) @(negedge clk);
   endtask : bang
   task automatic test_routes();
      send(24'hA5C3F0);
      check(refLatch, 24'hA5C3F0);
      send(24'h3C96E1);
      check(abLatch, 24'h3C96E1);
      check(refLatch, 24'hA5C3F0);
      send(24'h8001E2);
      check(funcLatch, 24'h8001E2);
      send(24'hFFFFFF);
      check(refLatch, 24'hA5C3F0);
      check(abLatch, 24'h3C96E1);
      check(funcLatch, 24'h8001E2);
      check({23'h0, wordError}, 24'h000000);
   endtask : test_routes
   task automatic test_power();
      powerDownReq = 1'b1;
      repeat (8) @(negedge clk);
      check({23'h0, poweredDown}, 24'h000001);
      send(24'h123454);
      check(refLatch, 24'h123454);
      lockDetect = 1'b1;
      send(24'h000012);
      powerDownReq = 1'b0;
      repeat (12) @(negedge clk);
      check({23'h0, lockStatus}, 24'h000001);
      check({23'h0, poweredDown}, 24'h000000);
      send(24'h00001A);
      repeat (12) @(negedge clk);
      check({23'h0, poweredDown}, 24'h000001);
      check({23'h0, lockStatus}, 24'h000000);
   endtask : test_power
   task automatic test_partial();
      bang(32'h00ABCDE4, 23);
      check({23'h0, badError}, 24'h000001);
      check(badRef, LATCH_RST);
      bang(32'h01ABCDE4, 25);
      check({23'h0, badError}, 24'h000001);
      check(badRef, LATCH_RST);
      bang(32'h00ABCD10, 24);
      check(badRef, 24'hABCD10);
      check({23'h0, badError}, 24'h000000);
   endtask : test_partial
   initial begin
      rst                = 1'b1;
      writeValid         = 1'b0;
      writeWord          = 24'h000000;
      powerDownReq       = 1'b0;
      lockDetect         = 1'b0;
      badLnk.serialClk   = 1'b0;
      badLnk.serialData  = 1'b0;
      badLnk.latchStrobe = 1'b1;
      badLnk.chipEnable  = 1'b1;
      repeat (3) @(negedge clk);
      rst = 1'b0;
      repeat (6) @(negedge clk);
      check(refLatch, LATCH_RST);
      test_routes();
      test_power();
      test_partial();
      complete_run();
   end
   initial begin
      #200000;
      num_errors++;
      complete_run();
   end
endmodule : synth_serial_latch_loader_test
